/* File: design/ppcfg_decode.sv */
// decodes the configuration byte and the device state into port controls.
// assumes all inputs are synchronous to core_clk_in; purely combinational.
`include "ppcfg_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module ppcfg_decode
(
    input  wire logic [7:0]          cfg_in,
    input  wire logic                active_in,
    input  wire logic                ecp_mode4_in,
    input  wire logic                ctl2_ver_in,
    output var ppcfg_pkg::ppcfg_ctrl_t ctrl_out
);

    ppcfg_pkg::ppcfg_mode_t mode;
    logic                   clk_run;

    always_comb
    begin
        mode    = ppcfg_pkg::ppcfg_mode_t'(cfg_in[`PPCFG_MODE_HI:`PPCFG_MODE_LO]);
        clk_run = active_in & cfg_in[`PPCFG_PWR_BIT];
        ctrl_out = '0;
        ctrl_out.port_clk_en = clk_run;
        ctrl_out.pins_float  = ~active_in & cfg_in[`PPCFG_FLOAT_BIT];
        unique case (mode)
            ppcfg_pkg::PPCFG_MODE_SPP:
            begin
                ctrl_out.data_out_force = 1'b1;
            end
            ppcfg_pkg::PPCFG_MODE_SPP_EXT:
            begin
                ctrl_out.data_dir_sw = 1'b1;
            end
            ppcfg_pkg::PPCFG_MODE_EPP17:
            begin
                ctrl_out.epp_on = 1'b1;
            end
            ppcfg_pkg::PPCFG_MODE_EPP19:
            begin
                ctrl_out.epp_on  = 1'b1;
                ctrl_out.epp_v19 = 1'b1;
            end
            ppcfg_pkg::PPCFG_MODE_ECP:
            begin
                ctrl_out.ecp_on = clk_run;
            end
            ppcfg_pkg::PPCFG_MODE_ECP_EPP:
            begin
                ctrl_out.ecp_on  = clk_run;
                ctrl_out.epp_on  = ecp_mode4_in;
                ctrl_out.epp_v19 = ecp_mode4_in & ctl2_ver_in;
            end
            ppcfg_pkg::PPCFG_MODE_RSV5,
            ppcfg_pkg::PPCFG_MODE_RSV6:
            begin
                ctrl_out.mode_reserved = 1'b1;
            end
        endcase
        // extended runtime registers only in extended ecp operation
        ctrl_out.ext_regs_on = cfg_in[`PPCFG_EXT_BIT] & ctrl_out.ecp_on;
    end

endmodule

`default_nettype wire

/* File: design/ppcfg_defs.svh */
// register offsets, field positions, reset values and decode constants
// for the parallel port configuration register bank.
// assumes inclusion by bare name from design and bench files.
`ifndef PPCFG_DEFS_SVH
`define PPCFG_DEFS_SVH

// byte addresses on the axi4-lite bus
`define PPCFG_CONFIG_ADDR    8'hF0
`define PPCFG_ACTIVATE_ADDR  8'hF4
`define PPCFG_STATUS_ADDR    8'hF8

// configuration register fields
`define PPCFG_MODE_HI        7
`define PPCFG_MODE_LO        5
`define PPCFG_EXT_BIT        4
`define PPCFG_PWR_BIT        1
`define PPCFG_FLOAT_BIT      0
`define PPCFG_WMASK          8'hF3
`define PPCFG_RESET          8'hF2

// extended runtime register offsets, relative to the port base
`define PPCFG_EXT_LO         12'h403
`define PPCFG_EXT_HI         12'h405
`define PPCFG_CTL2_OFS       12'h002
`define PPCFG_CTL2_VER_BIT   4

// axi responses
`define PPCFG_RESP_OKAY      2'h0
`define PPCFG_RESP_SLVERR    2'h2

`endif

/* File: design/ppcfg_pkg.sv */
// types shared by the parallel port configuration block.
// assumes ppcfg_defs.svh supplies the numeric constants.
package ppcfg_pkg;

    typedef enum logic [2:0]
    {
        PPCFG_MODE_SPP     = 3'h0,
        PPCFG_MODE_SPP_EXT = 3'h1,
        PPCFG_MODE_EPP17   = 3'h2,
        PPCFG_MODE_EPP19   = 3'h3,
        PPCFG_MODE_ECP     = 3'h4,
        PPCFG_MODE_RSV5    = 3'h5,
        PPCFG_MODE_RSV6    = 3'h6,
        PPCFG_MODE_ECP_EPP = 3'h7
    } ppcfg_mode_t;

    typedef struct packed
    {
        logic       data_out_force;
        logic       data_dir_sw;
        logic       epp_on;
        logic       epp_v19;
        logic       ecp_on;
        logic       ext_regs_on;
        logic       port_clk_en;
        logic       pins_float;
        logic       mode_reserved;
    } ppcfg_ctrl_t;

endpackage

/* File: design/ppcfg_top.sv */
// parallel port configuration register with axi4-lite access and the
// controls it drives into the port: mode, pin direction, clock gate, float.
// assumes one clock, synchronous inputs, a single-beat axi4-lite master.
`include "ppcfg_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - hardware reset loads the configuration register with F2h.
// - mode 000 is compatible mode; data lines always driven as outputs.
// - mode 001 is extended compatible; software sets data line direction.
// - mode 100 is ecp without epp; codes 101 and 110 are reserved.
// - mode 111, the default, is ecp with epp reachable as mode 4.
// - 010/011 select epp 1.7/1.9; in mode 4 version follows second_runtime_control_reg bit 4.
// - extended access bit clear makes registers 403h to 405h ignore accesses.
// - extended access bit set, the default, exposes the three extended registers.
// - power bit clear stops port clock; ecp and epp time-out stop; registers kept.
// - power bit set, the default, runs the clock; all modes work when active.
// - float bit set and device inactive floats outputs; clear, the default, does not.
// - extended registers 403h to 405h are used only in extended ecp operation.
module ppcfg_top
(
    input  wire logic        core_clk_in,
    input  wire logic        sys_rst_in,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    // port side state
    input  wire logic        ecp_mode4_in,
    input  wire logic        second_runtime_control_reg_in,
    input  wire logic [11:0] rt_addr_in,
    input  wire logic        rt_strobe_in,
    // port controls
    output logic             parallel_data_lines_force_out,
    output logic             parallel_data_lines_dir_sw_out,
    output logic             epp_enable_out,
    output logic             epp_v19_out,
    output logic             ecp_enable_out,
    output logic             port_clk_en_out,
    output logic             pins_float_out,
    output logic             rt_ext_hit_out
);

    // ****************************************************************
    // state
    // ****************************************************************
    logic [7:0]             cfg_q;
    logic                   active_q;
    logic                   aw_held_q;
    logic                   w_held_q;
    logic [7:0]             awaddr_q;
    logic [31:0]            wdata_q;
    logic [3:0]             wstrb_q;
    ppcfg_pkg::ppcfg_ctrl_t ctrl;
    logic                   do_write;
    logic [7:0]             wr_addr;
    logic [31:0]            wr_data;
    logic [3:0]             wr_strb;

    // ****************************************************************
    // address decode; addr_mapped shared by read and write paths, addr_writable used by writes only
    // ****************************************************************
    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a == `PPCFG_CONFIG_ADDR) || (a == `PPCFG_ACTIVATE_ADDR)
                   || (a == `PPCFG_STATUS_ADDR);
    endfunction

    function automatic logic addr_writable(input logic [7:0] a);
        addr_writable = (a == `PPCFG_CONFIG_ADDR) || (a == `PPCFG_ACTIVATE_ADDR);
    endfunction

    // ****************************************************************
    // write channel: address and data taken in either order
    // ****************************************************************
    assign wr_addr  = aw_held_q ? awaddr_q : s_axi_awaddr_in;
    assign wr_data  = w_held_q ? wdata_q : s_axi_wdata_in;
    assign wr_strb  = w_held_q ? wstrb_q : s_axi_wstrb_in;
    assign do_write = (aw_held_q | (s_axi_awvalid_in & s_axi_awready_out))
                    & (w_held_q | (s_axi_wvalid_in & s_axi_wready_out))
                    & ~s_axi_bvalid_out;

    // write address channel
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            aw_held_q         <= 1'b0;
            awaddr_q          <= 8'h00;
            s_axi_awready_out <= 1'b0;
        end
        else if (do_write)
        begin
            aw_held_q         <= 1'b0;
            s_axi_awready_out <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid_in & s_axi_awready_out)
            begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr_in;
            end
            // one outstanding write: ready only while nothing pending
            s_axi_awready_out <= ~aw_held_q & ~s_axi_bvalid_out
                               & ~(s_axi_awvalid_in & s_axi_awready_out);
        end
    end

    // write data channel
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            w_held_q         <= 1'b0;
            wdata_q          <= 32'h0000_0000;
            wstrb_q          <= 4'h0;
            s_axi_wready_out <= 1'b0;
        end
        else if (do_write)
        begin
            w_held_q         <= 1'b0;
            s_axi_wready_out <= 1'b0;
        end
        else
        begin
            if (s_axi_wvalid_in & s_axi_wready_out)
            begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata_in;
                wstrb_q  <= s_axi_wstrb_in;
            end
            s_axi_wready_out <= ~w_held_q & ~s_axi_bvalid_out
                              & ~(s_axi_wvalid_in & s_axi_wready_out);
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= `PPCFG_RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= addr_mapped(wr_addr) ? `PPCFG_RESP_OKAY : `PPCFG_RESP_SLVERR;
        end
        else if (s_axi_bready_in)
        begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    // ****************************************************************
    // configuration and activation registers
    // ****************************************************************
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            cfg_q <= `PPCFG_RESET;
        end
        else if (do_write && wr_addr == `PPCFG_CONFIG_ADDR && wr_strb[0])
        begin
            // mode change is not guarded; software prepares the port first
            cfg_q <= wr_data[7:0] & `PPCFG_WMASK;
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            active_q <= 1'b0;
        end
        else if (do_write && addr_writable(wr_addr) && wr_addr == `PPCFG_ACTIVATE_ADDR
                 && wr_strb[0])
        begin
            active_q <= wr_data[0];
        end
    end

    // ****************************************************************
    // read channel
    // ****************************************************************
    // address ready: one read at a time, so low while data waits
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            s_axi_arready_out <= 1'b0;
        end
        else
        begin
            s_axi_arready_out <= ~s_axi_rvalid_out
                               & ~(s_axi_arvalid_in & s_axi_arready_out);
        end
    end

    // read valid and response stand until the master takes them
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rresp_out  <= `PPCFG_RESP_OKAY;
        end
        else if (s_axi_arvalid_in & s_axi_arready_out)
        begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out  <= addr_mapped(s_axi_araddr_in)
                              ? `PPCFG_RESP_OKAY : `PPCFG_RESP_SLVERR;
        end
        else if (s_axi_rready_in)
        begin
            s_axi_rvalid_out <= 1'b0;
        end
    end

    // read data captured once per accepted address
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            s_axi_rdata_out <= 32'h0000_0000;
        end
        else if (s_axi_arvalid_in & s_axi_arready_out)
        begin
            unique case (s_axi_araddr_in)
                `PPCFG_CONFIG_ADDR:   s_axi_rdata_out <= {24'h000000, cfg_q};
                `PPCFG_ACTIVATE_ADDR: s_axi_rdata_out <= {31'h00000000, active_q};
                `PPCFG_STATUS_ADDR:   s_axi_rdata_out <= {23'h000000, ctrl};
                default:              s_axi_rdata_out <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************************
    // decode into port controls
    // ****************************************************************
    ppcfg_decode u_decode
    (
        .cfg_in       (cfg_q),
        .active_in    (active_q),
        .ecp_mode4_in (ecp_mode4_in),
        .ctl2_ver_in  (second_runtime_control_reg_in),
        .ctrl_out     (ctrl)
    );

    // registered so every port control comes from a flip-flop
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            parallel_data_lines_force_out  <= 1'b0;
            parallel_data_lines_dir_sw_out <= 1'b0;
            epp_enable_out                 <= 1'b0;
            epp_v19_out                    <= 1'b0;
            ecp_enable_out                 <= 1'b0;
            port_clk_en_out                <= 1'b0;
            pins_float_out                 <= 1'b0;
        end
        else
        begin
            parallel_data_lines_force_out  <= ctrl.data_out_force;
            parallel_data_lines_dir_sw_out <= ctrl.data_dir_sw;
            epp_enable_out                 <= ctrl.epp_on;
            epp_v19_out                    <= ctrl.epp_v19;
            ecp_enable_out                 <= ctrl.ecp_on;
            port_clk_en_out                <= ctrl.port_clk_en;
            pins_float_out                 <= ctrl.pins_float;
        end
    end

    // ****************************************************************
    // extended runtime register gate
    // ****************************************************************
    // accesses to base+403h..405h pass only when enabled; otherwise dropped
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            rt_ext_hit_out <= 1'b0;
        end
        else
        begin
            rt_ext_hit_out <= rt_strobe_in && ctrl.ext_regs_on
                           && rt_addr_in >= `PPCFG_EXT_LO && rt_addr_in <= `PPCFG_EXT_HI;
        end
    end

endmodule

`default_nettype wire

/* File: verif/parallel_port_config_register_bench.sv */
// self-checking bench for the parallel port configuration block.
// assumes ppcfg_top with its axi4-lite slave and the ppcfg_defs.svh constants.
`include "ppcfg_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module parallel_port_config_register_bench;
    logic        clk, rst, aw_valid, aw_ready, w_valid, w_ready, b_valid, b_ready;
    logic        ar_valid, ar_ready, r_valid, r_ready, ecp_m4, ctl2, rt_stb, hit;
    logic [7:0]  aw_addr, ar_addr;
    logic [31:0] w_data, r_data, rd_v, seed;
    logic [3:0]  w_strb;
    logic [1:0]  b_resp, r_resp, rs_v;
    logic [11:0] rt_addr;
    wire logic [6:0] outs;
    int          miscompares, compares;

    ppcfg_top DUT
    (
        .core_clk_in(clk), .sys_rst_in(rst), .s_axi_awaddr_in(aw_addr),
        .s_axi_awvalid_in(aw_valid), .s_axi_awready_out(aw_ready), .s_axi_wdata_in(w_data),
        .s_axi_wstrb_in(w_strb), .s_axi_wvalid_in(w_valid), .s_axi_wready_out(w_ready),
        .s_axi_bresp_out(b_resp), .s_axi_bvalid_out(b_valid), .s_axi_bready_in(b_ready),
        .s_axi_araddr_in(ar_addr), .s_axi_arvalid_in(ar_valid), .s_axi_arready_out(ar_ready),
        .s_axi_rdata_out(r_data), .s_axi_rresp_out(r_resp), .s_axi_rvalid_out(r_valid),
        .s_axi_rready_in(r_ready), .ecp_mode4_in(ecp_m4),
        .second_runtime_control_reg_in(ctl2), .rt_addr_in(rt_addr), .rt_strobe_in(rt_stb),
        .parallel_data_lines_force_out(outs[6]), .parallel_data_lines_dir_sw_out(outs[5]),
        .epp_enable_out(outs[4]), .epp_v19_out(outs[3]), .ecp_enable_out(outs[2]),
        .port_clk_en_out(outs[1]), .pins_float_out(outs[0]), .rt_ext_hit_out(hit)
    );

    // ****************************************
    // expectations and bus tasks
    // ****************************************
    // order: force, dir_sw, epp, v19, ecp, clock, float
    function automatic logic [6:0] exp_out(input logic [7:0] c, input logic a, m4, c2);
        logic [2:0] m;
        m = c[7:5];
        return {m == 3'h0, m == 3'h1, m == 3'h2 || m == 3'h3 || (m == 3'h7 && m4),
            m == 3'h3 || (m == 3'h7 && m4 && c2), (m == 3'h4 || m == 3'h7) && a && c[1],
            a && c[1], !a && c[0]};
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask

    task automatic chk_port(input logic [6:0] g, input logic [6:0] e);
        chk(32'(g), 32'(e));
    endtask

    task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
        chk(32'(g), 32'(e));
    endtask

    task automatic test_done();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // every wait is bounded; a hung handshake ends the run
    task automatic tick(inout int n);
        @(posedge clk);
        n++;
        if (n > 100)
        begin
            miscompares++;
            $display("wrong value at %0t: handshake timeout", $time);
            test_done();
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int   n;
        logic ad, wd;
        n = 0;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge clk);
        aw_addr <= a;
        aw_valid <= 1'b1;
        w_data <= d;
        w_valid <= 1'b1;
        b_ready <= 1'b1;
        while (!(ad && wd))
        begin
            tick(n);
            if (!ad && aw_ready === 1'b1)
            begin
                ad = 1'b1;
                aw_valid <= 1'b0;
            end
            if (!wd && w_ready === 1'b1)
            begin
                wd = 1'b1;
                w_valid <= 1'b0;
            end
        end
        while (b_valid !== 1'b1)
            tick(n);
        r = b_resp;
        b_ready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        ar_addr <= a;
        ar_valid <= 1'b1;
        r_ready <= 1'b1;
        do tick(n); while (ar_ready !== 1'b1);
        ar_valid <= 1'b0;
        while (r_valid !== 1'b1)
            tick(n);
        d = r_data;
        r = r_resp;
        r_ready <= 1'b0;
    endtask

    task automatic apply(input logic [7:0] c, input logic a);
        logic [1:0]  r;
        logic [6:0]  e;
        logic [11:0] ra;
        ecp_m4 <= 1'($urandom_range(1));
        ctl2 <= 1'($urandom_range(1));
        axw(`PPCFG_CONFIG_ADDR, {24'h0, c}, r);
        chk_resp(r, `PPCFG_RESP_OKAY);
        axw(`PPCFG_ACTIVATE_ADDR, {31'h0, a}, r);
        axr(`PPCFG_CONFIG_ADDR, rd_v, r);
        chk(rd_v, {24'h0, c & `PPCFG_WMASK});
        chk_resp(r, `PPCFG_RESP_OKAY);
        axr(`PPCFG_ACTIVATE_ADDR, rd_v, r);
        chk(rd_v, {31'h0, a});
        repeat (2) @(posedge clk);
        #1;
        e = exp_out(c, a, ecp_m4, ctl2);
        chk_port(outs, e);
        axr(`PPCFG_STATUS_ADDR, rd_v, r);
        chk(rd_v, {23'h0, e[6:2], c[4] & e[2], e[1:0], (c[7:5] inside {3'h5, 3'h6})});
        ra = 12'h402 + 12'($urandom_range(4));
        @(posedge clk);
        rt_addr <= ra;
        rt_stb <= 1'b1;
        @(posedge clk);
        rt_stb <= 1'b0;
        #1;
        e[6] = (ra >= `PPCFG_EXT_LO && ra <= `PPCFG_EXT_HI && c[4] && e[2]);
        chk_port({6'h0, hit}, {6'h0, e[6]});
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial
    begin
        logic [7:0] c;
        {rst, aw_valid, w_valid, b_ready, ar_valid, r_ready, ecp_m4, ctl2, rt_stb} = 9'h100;
        {aw_addr, ar_addr, w_data, rt_addr} = 60'h0;
        w_strb = 4'hF;
        miscompares = 0;
        compares = 0;
        seed = $urandom(13585);
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        axr(`PPCFG_CONFIG_ADDR, rd_v, rs_v);
        chk(rd_v, 32'(`PPCFG_RESET));
        chk_port(outs, exp_out(`PPCFG_RESET, 1'b0, 1'b0, 1'b0));
        // every mode code, inactive with clock off and float set, then active
        for (int i = 0; i < 16; i++)
            apply({i[2:0], 1'b1, 2'b11, i[3], 1'b1}, i[3]);
        for (int i = 0; i < 40; i++)
        begin
            c = 8'($urandom);
            if (c[7:5] inside {3'h5, 3'h6})
                c[7] = 1'b0;
            apply(c, 1'($urandom_range(1)));
        end
        axw(8'h10, 32'hFF, rs_v);
        chk_resp(rs_v, `PPCFG_RESP_SLVERR);
        axr(8'h10, rd_v, rs_v);
        chk_resp(rs_v, `PPCFG_RESP_SLVERR);
        // a write with the low byte lane off must leave the register alone
        w_strb <= 4'hE;
        axw(`PPCFG_CONFIG_ADDR, 32'h0, rs_v);
        w_strb <= 4'hF;
        axr(`PPCFG_CONFIG_ADDR, rd_v, rs_v);
        chk(rd_v, {24'h0, c & `PPCFG_WMASK});
        // a second reset in mid-run must restore the default
        axw(`PPCFG_CONFIG_ADDR, 32'h0, rs_v);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        axr(`PPCFG_CONFIG_ADDR, rd_v, rs_v);
        chk(rd_v, 32'(`PPCFG_RESET));
        chk_port(outs, exp_out(`PPCFG_RESET, 1'b0, ecp_m4, ctl2));
        test_done();
    end
endmodule

`default_nettype wire

/* File: verif/ppcfg_sva.sv */
// assertion checker for the parallel port configuration block.
// assumes it is bound into ppcfg_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module ppcfg_sva
(
    input  wire logic        core_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        s_axi_awready_out,
    input  wire logic        s_axi_wready_out,
    input  wire logic        s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic        s_axi_arvalid_in,
    input  wire logic        s_axi_arready_out,
    input  wire logic [31:0] s_axi_rdata_out,
    input  wire logic        s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    input  wire logic        ecp_mode4_in,
    input  wire logic [11:0] rt_addr_in,
    input  wire logic        rt_strobe_in,
    input  wire logic        parallel_data_lines_force_out,
    input  wire logic        parallel_data_lines_dir_sw_out,
    input  wire logic        epp_enable_out,
    input  wire logic        epp_v19_out,
    input  wire logic        ecp_enable_out,
    input  wire logic        port_clk_en_out,
    input  wire logic        pins_float_out,
    input  wire logic        rt_ext_hit_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    a_ecp_needs_clk: assert property (ecp_enable_out |-> port_clk_en_out)
        else $error("ecp enabled while port clock stopped");
    a_float_inactive: assert property (pins_float_out |-> !port_clk_en_out)
        else $error("pins floated while device active");
    a_force_alone: assert property (parallel_data_lines_force_out |->
        !(parallel_data_lines_dir_sw_out || epp_enable_out || ecp_enable_out))
        else $error("compatible mode mixed with another mode");
    a_v19_with_epp: assert property (epp_v19_out |-> epp_enable_out)
        else $error("epp version set without epp");
    a_epp_mode4: assert property (epp_enable_out && ecp_enable_out |-> $past(ecp_mode4_in))
        else $error("epp beside ecp without mode 4");
    a_hit_window: assert property (rt_ext_hit_out |-> $past(rt_strobe_in) &&
        $past(rt_addr_in) >= 12'h403 && $past(rt_addr_in) <= 12'h405)
        else $error("extended hit outside its window");
    a_write_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
        else $error("write response dropped early");
    a_write_block: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
        else $error("write accepted while response pending");
    a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read data late");
    a_read_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
        s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data not held");

    c_ecp_on: cover property (ecp_enable_out);
    c_ext_hit: cover property (rt_ext_hit_out);
    c_float: cover property (pins_float_out);
endmodule

bind ppcfg_top ppcfg_sva u_sva
(
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .s_axi_awready_out(s_axi_awready_out), .s_axi_wready_out(s_axi_wready_out),
    .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
    .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
    .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rvalid_out(s_axi_rvalid_out),
    .s_axi_rready_in(s_axi_rready_in), .ecp_mode4_in(ecp_mode4_in),
    .rt_addr_in(rt_addr_in), .rt_strobe_in(rt_strobe_in),
    .parallel_data_lines_force_out(parallel_data_lines_force_out),
    .parallel_data_lines_dir_sw_out(parallel_data_lines_dir_sw_out),
    .epp_enable_out(epp_enable_out), .epp_v19_out(epp_v19_out),
    .ecp_enable_out(ecp_enable_out), .port_clk_en_out(port_clk_en_out),
    .pins_float_out(pins_float_out), .rt_ext_hit_out(rt_ext_hit_out)
);

`default_nettype wire
